// [core/tdc_dma_ctrl.sv]
// Behaviour
// [RL1] Terminated channel gets no grants until rearmed.
// [RL2] Suspended channel resumes without rearming.
// [RL3] Terminate on count disarms at zero count.
// [RL4] Unsynchronized channels always terminate at zero count.
// [RL5] Disarm lets current transfer finish, no more.
// [RL6] NMI service blocks DMA; return or software reenables.
// [RL7] Software can suspend DMA without disarming.
// [RL8] Channel raises interrupt at zero count if enabled.
// [RL9] Pending request signalled to bus interface unit.
// [RL10] Non-CPU master status high during DMA cycles.
// [RL11] No chip select for I/O above 64K.
// [RL12] Fixed priority: high channel wins and holds.
// [RL13] After high release, low runs one transfer.
// [RL14] High request preempts low at transfer boundary.
// [RL15] Equal priority rotates, channel 1 first.
// [RL16] Bus release gives channel 1 priority again.
// [RL17] Each pointer is two 16-bit halves.
// [RL18] High pointer bits always drive the address bus.
// [RL19] Software clears high bits for 64K I/O.
// [RL20] Source pointer drives address during fetch.
// [RL21] Destination pointer drives address during deposit.
// [RL22] Equal increment and decrement keep pointer constant.
// [RL23] Space select bit per pointer: memory or I/O.
// [RL24] Software writes zero to reserved pointer bits.
// [RL25] Word steps by two, byte by one.
// [RL26] Transfer count drops by one per transfer.
// [RL27] Armed bit changes only with change enable.
// [RL28] Count interrupt needs terminate on count set.
// [RL29] No arbitration inside a fetch/deposit pair.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"

module tdc_dma_ctrl
    import tdc_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int CNT_W  = 16
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port.
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWrData,
    output var  logic [15:0] regRdData_r,
    // Channel requests and interrupt service.
    input  wire logic [1:0]  chanReq,
    input  wire logic        nmiEntry,
    input  wire logic        nmiExit,
    // Bus interface unit.
    input  wire logic        biuGrant,
    input  wire logic        biuCycleDone,
    output var  logic        dmaReq_r,
    output var  tdc_addr_t   busAddr_r,
    output var  logic        busMemSpace_r,
    output var  logic        busWrite_r,
    output var  logic        nonCpuMasterStatus_r,
    output var  logic        chipSelAllow_r,
    // Terminal count interrupt requests.
    output var  logic [1:0]  tcIrq
);

    if (NUM_CH != 2) begin : gBadCh
        $error("tdc_dma_ctrl serves exactly two channels");
    end
    if (CNT_W < 1 || CNT_W > 16) begin : gBadCnt
        $error("tdc_dma_ctrl count width must be 1 to 16");
    end

    // Channel state.
    tdc_addr_t        src [2];
    tdc_addr_t        dst [2];
    logic [CNT_W-1:0] cnt [2];
    logic [15:0]      ctl [2];
    logic [1:0]       elig;
    logic [1:0]       prio;
    logic [1:0]       dstSync;
    logic [1:0]       chXfer;
    logic             depDone;

    // Control state.
    tdc_state_e state_r;
    tdc_state_e state_nxt;
    logic       cur_r;
    logic       rotFav_r;
    logic       lowTurn_r;
    logic [1:0] idleCnt_r;
    logic       softSusp_r;
    logic       nmiHold_r;

    genvar g;
    for (g = 0; g < 2; g++) begin : gCh
        wire chWr = regWr && regAddr[4:3] == 2'(g);

        tdc_channel #(
            .CNT_W(CNT_W)
        ) uChan (
            .clk     (clk),
            .rst     (rst),
            .wrEn    (chWr),
            .wrSel   (regAddr[2:0]),
            .wrData  (regWrData),
            .xferDone(chXfer[g]),
            .srcPtr  (src[g]),
            .dstPtr  (dst[g]),
            .count   (cnt[g]),
            .ctl     (ctl[g]),
            .tcIrq   (tcIrq[g])
        );

        // Only an armed channel is eligible; suspension never touches armed.
        assign elig[g]    = ctl[g][`TDC_B_ARMED] && chanReq[g]; // [RL1] [RL2] [RL5]
        assign prio[g]    = ctl[g][`TDC_B_PRIO];
        assign dstSync[g] = ctl[g][`TDC_B_SYNHI:`TDC_B_SYNLO] == SYN_DST;
        assign chXfer[g]  = depDone && cur_r == 1'(g);
    end

    // Suspension sources.
    wire hold   = nmiHold_r || softSusp_r; // [RL6] [RL7]
    wire isIdle = state_r == ST_IDLE;
    wire canReq = isIdle && !hold && |elig; // [RL9]

    // Arbitration runs only while idle, so a pair is never split.
    wire fixed     = prio[0] ^ prio[1];
    wire hiCh      = prio[1];
    wire loCh      = !prio[1];
    wire pickFixed = (lowTurn_r && elig[loCh]) ? loCh : // [RL13]
                     (elig[hiCh] ? hiCh : loCh); // [RL12] [RL14]
    wire pickRot   = elig[rotFav_r] ? rotFav_r : !rotFav_r; // [RL15]
    wire pick      = fixed ? pickFixed : pickRot;

    // Bus phase events.
    wire take      = canReq && dmaReq_r && biuGrant; // [RL9] [RL29]
    wire fetchDone = state_r == ST_FETCH && biuCycleDone;
    assign depDone = state_r == ST_DEPOSIT && biuCycleDone;
    wire relEnd    = state_r == ST_RELEASE && idleCnt_r == `TDC_IDLE_CYC - 2'h1;
    wire idleFree  = isIdle && elig == 2'b00;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (biuCycleDone) begin
                    state_nxt = ST_DEPOSIT; // [RL29]
                end
            end
            ST_DEPOSIT: begin
                if (biuCycleDone) begin
                    state_nxt = dstSync[cur_r] ? ST_RELEASE : ST_IDLE;
                end
            end
            ST_RELEASE: begin
                if (relEnd) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // Bus outputs; high pointer bits go out even for I/O cycles.
    wire tdc_addr_t addrNxt = take ? src[pick] : // [RL18] [RL20]
                              fetchDone ? dst[cur_r] : busAddr_r; // [RL21]
    wire memNxt    = take ? ctl[pick][`TDC_B_SOURCE_SPACE_SELECT] : // [RL23]
                     fetchDone ? ctl[cur_r][`TDC_B_DEST_SPACE_SELECT] : busMemSpace_r; // [RL23]
    wire writeNxt  = take ? 1'b0 : fetchDone ? 1'b1 : busWrite_r;
    wire masterNxt = take ? 1'b1 : depDone ? 1'b0 : nonCpuMasterStatus_r; // [RL10]
    wire csNxt     = masterNxt && (memNxt || addrNxt[19:16] == 4'h0); // [RL11]
    wire reqNxt    = canReq && !take; // [RL9]

    // Priority bookkeeping.
    wire rotNxt  = (relEnd || idleFree) ? 1'b1 : // [RL16]
                   depDone ? !cur_r : rotFav_r; // [RL15]
    wire turnNxt = take ? 1'b0 :
                   (relEnd && fixed && cur_r == hiCh) ? 1'b1 : lowTurn_r; // [RL13]
    wire [1:0] idleNxt = state_r == ST_RELEASE ? idleCnt_r + 2'h1 : 2'h0;

    // Unit control: an NMI entry wins over a release in the same cycle.
    wire uWr     = regWr && regAddr == `TDC_R_UCTL;
    wire nmiRel  = nmiExit || (uWr && regWrData[`TDC_U_NMI]);
    wire nmiNxt  = nmiEntry ? 1'b1 : nmiRel ? 1'b0 : nmiHold_r; // [RL6]
    wire suspNxt = uWr ? regWrData[`TDC_U_SUSP] : softSusp_r; // [RL7]

    // Read decode; unmapped addresses read as zero.
    wire rdCh = regAddr[3];
    wire [15:0] uctlRd = {11'h0, ctl[1][`TDC_B_ARMED], ctl[0][`TDC_B_ARMED],
                          !isIdle, nmiHold_r, softSusp_r};
    wire [15:0] chRd =
        regAddr[2:0] == `TDC_R_SRCL ? src[rdCh][15:0] :
        regAddr[2:0] == `TDC_R_SRCH ? {12'h0, src[rdCh][19:16]} :
        regAddr[2:0] == `TDC_R_DSTL ? dst[rdCh][15:0] :
        regAddr[2:0] == `TDC_R_DSTH ? {12'h0, dst[rdCh][19:16]} :
        regAddr[2:0] == `TDC_R_CNT  ? 16'(cnt[rdCh]) :
        regAddr[2:0] == `TDC_R_CON  ? ctl[rdCh] : 16'h0;
    wire [15:0] rdMux = regAddr == `TDC_R_UCTL ? uctlRd :
                        !regAddr[4] ? chRd : 16'h0;
    wire [15:0] rdNxt = regRd ? rdMux : regRdData_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            cur_r     <= 1'b0;
            rotFav_r  <= 1'b1;
            lowTurn_r <= 1'b0;
            idleCnt_r <= 2'h0;
        end else begin
            state_r   <= state_nxt;
            cur_r     <= take ? pick : cur_r;
            rotFav_r  <= rotNxt;
            lowTurn_r <= turnNxt;
            idleCnt_r <= idleNxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaReq_r             <= 1'b0;
            busAddr_r            <= '0;
            busMemSpace_r        <= 1'b0;
            busWrite_r           <= 1'b0;
            nonCpuMasterStatus_r <= 1'b0;
            chipSelAllow_r       <= 1'b0;
        end else begin
            dmaReq_r             <= reqNxt;
            busAddr_r            <= addrNxt;
            busMemSpace_r        <= memNxt;
            busWrite_r           <= writeNxt;
            nonCpuMasterStatus_r <= masterNxt;
            chipSelAllow_r       <= csNxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            softSusp_r  <= 1'b0;
            nmiHold_r   <= 1'b0;
            regRdData_r <= 16'h0;
        end else begin
            softSusp_r  <= suspNxt;
            nmiHold_r   <= nmiNxt;
            regRdData_r <= rdNxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence sTake;
        isIdle && take;
    endsequence

    sequence sFetchDone;
        fetchDone;
    endsequence

    sequence sDstRelease;
        depDone && dstSync[cur_r];
    endsequence

    a_fetch_addr: assert property (sTake |=> busAddr_r == $past(src[pick]) && !busWrite_r) // [RL20]
        else $error("fetch address is not the source pointer");
    a_deposit_addr: assert property (sFetchDone |=> busAddr_r == $past(dst[cur_r]) && busWrite_r) // [RL21]
        else $error("deposit address is not the destination pointer");
    a_status_high: assert property (sTake |=> nonCpuMasterStatus_r && state_r == ST_FETCH) // [RL10]
        else $error("non-CPU status low in DMA cycle");
    a_cs_block: assert property (!busMemSpace_r && busAddr_r[19:16] != 4'h0 |-> !chipSelAllow_r) // [RL11]
        else $error("chip select allowed above 64K I/O");
    a_nmi_block: assert property (nmiHold_r |=> !dmaReq_r) // [RL6]
        else $error("DMA requested during NMI service");
    a_soft_susp: assert property (softSusp_r |=> !dmaReq_r) // [RL7]
        else $error("DMA requested while suspended");
    a_pair_whole: assert property (sFetchDone |=> state_r == ST_DEPOSIT && cur_r == $past(cur_r)) // [RL29]
        else $error("transfer pair broken");
    a_fixed_high: assert property ((sTake and (fixed && elig == 2'b11 && !lowTurn_r)) // [RL12]
        |=> cur_r == $past(hiCh))
        else $error("high priority channel lost arbitration");
    a_low_turn: assert property ((sTake and (fixed && lowTurn_r && elig[loCh])) // [RL13]
        |=> cur_r == $past(loCh))
        else $error("low channel missed its turn after release");
    a_rotate_pick: assert property ((sTake and (!fixed && elig == 2'b11)) // [RL15]
        |=> cur_r == $past(rotFav_r))
        else $error("rotation picked the wrong channel");
    a_release_len: assert property (sDstRelease |=> state_r == ST_RELEASE [*2] ##1 isIdle && rotFav_r) // [RL16]
        else $error("release idle states wrong");

endmodule
`default_nettype wire

// [include/tdc_map.svh]
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH

// Register index within a channel window.
`define TDC_R_SRCL 3'h0
`define TDC_R_SRCH 3'h1
`define TDC_R_DSTL 3'h2
`define TDC_R_DSTH 3'h3
`define TDC_R_CNT  3'h4
`define TDC_R_CON  3'h5

// Unit control register address.
`define TDC_R_UCTL 5'h10

// Channel control field positions.
`define TDC_B_WORD  0
`define TDC_B_ARMED 1
`define TDC_B_CHG   2
`define TDC_B_PRIO  4
`define TDC_B_SYNLO 5
`define TDC_B_SYNHI 6
`define TDC_B_IRQEN 8
`define TDC_B_TOC   9
`define TDC_B_SINC  10
`define TDC_B_SDEC  11
`define TDC_B_SOURCE_SPACE_SELECT  12
`define TDC_B_DINC  13
`define TDC_B_DDEC  14
`define TDC_B_DEST_SPACE_SELECT  15

// Writable control bits and reset value.
`define TDC_CON_MASK 16'hff73
`define TDC_CON_RST  16'h0000

// Unit control field positions.
`define TDC_U_SUSP 0
`define TDC_U_NMI  1
`define TDC_U_BUSY 2

// Idle states after a destination-synchronized deposit.
`define TDC_IDLE_CYC 2'h2

`endif

// [include/tdc_pkg.sv]
package tdc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_FETCH   = 4'b0010,
        ST_DEPOSIT = 4'b0100,
        ST_RELEASE = 4'b1000
    } tdc_state_e;

    typedef enum logic [1:0] {
        SYN_NONE = 2'b00,
        SYN_SRC  = 2'b01,
        SYN_DST  = 2'b10
    } tdc_syn_e;

    typedef logic [19:0] tdc_addr_t;

endpackage

// [core/tdc_channel.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"

module tdc_channel
    import tdc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Register writes.
    input  wire logic             wrEn,
    input  wire logic [2:0]       wrSel,
    input  wire logic [15:0]      wrData,
    // Completed transfer.
    input  wire logic             xferDone,
    // Channel state.
    output var  tdc_addr_t        srcPtr,
    output var  tdc_addr_t        dstPtr,
    output var  logic [CNT_W-1:0] count,
    output var  logic [15:0]      ctl,
    output var  logic             tcIrq
);

    function automatic tdc_addr_t stepPtr(tdc_addr_t p, logic inc, logic dec, tdc_addr_t s);
        if (inc == dec) begin
            return p;
        end
        return inc ? p + s : p - s;
    endfunction

    wire wSrcL = wrEn && wrSel == `TDC_R_SRCL;
    wire wSrcH = wrEn && wrSel == `TDC_R_SRCH;
    wire wDstL = wrEn && wrSel == `TDC_R_DSTL;
    wire wDstH = wrEn && wrSel == `TDC_R_DSTH;
    wire wCnt  = wrEn && wrSel == `TDC_R_CNT;
    wire wCon  = wrEn && wrSel == `TDC_R_CON;

    wire tdc_addr_t step = ctl[`TDC_B_WORD] ? 20'h2 : 20'h1; // [RL25]
    wire unsync = ctl[`TDC_B_SYNHI:`TDC_B_SYNLO] == SYN_NONE;
    wire effToc = ctl[`TDC_B_TOC] | unsync; // [RL4]
    wire endCnt = xferDone && count == CNT_W'(1);

    wire tdc_addr_t srcStep = stepPtr(srcPtr, ctl[`TDC_B_SINC], ctl[`TDC_B_SDEC], step); // [RL22]
    wire tdc_addr_t dstStep = stepPtr(dstPtr, ctl[`TDC_B_DINC], ctl[`TDC_B_DDEC], step); // [RL22]

    // Pointers live as low and high halves; a software write wins over a step.
    wire tdc_addr_t srcNxt = wSrcL ? {srcPtr[19:16], wrData} :
                             wSrcH ? {wrData[3:0], srcPtr[15:0]} :
                             xferDone ? srcStep : srcPtr; // [RL17]
    wire tdc_addr_t dstNxt = wDstL ? {dstPtr[19:16], wrData} :
                             wDstH ? {wrData[3:0], dstPtr[15:0]} :
                             xferDone ? dstStep : dstPtr; // [RL17]
    wire [CNT_W-1:0] cntNxt = wCnt ? wrData[CNT_W-1:0] :
                              xferDone ? count - CNT_W'(1) : count; // [RL26]

    // Arming needs the change bit; a software arm wins over terminal count.
    wire armNxt = (wCon && wrData[`TDC_B_CHG]) ? wrData[`TDC_B_ARMED] : // [RL27]
                  (endCnt && effToc) ? 1'b0 : ctl[`TDC_B_ARMED]; // [RL3] [RL4]
    wire [15:0] conBits = wCon ? (wrData & `TDC_CON_MASK) : ctl;
    wire [15:0] ctlNxt = {conBits[15:2], armNxt, conBits[0]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srcPtr <= '0;
            dstPtr <= '0;
            count  <= '0;
            ctl    <= `TDC_CON_RST;
            tcIrq  <= 1'b0;
        end else begin
            srcPtr <= srcNxt;
            dstPtr <= dstNxt;
            count  <= cntNxt;
            ctl    <= ctlNxt;
            tcIrq  <= endCnt && ctl[`TDC_B_TOC] && ctl[`TDC_B_IRQEN]; // [RL8] [RL28]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_tc_disarm: assert property (endCnt && effToc && !wCon |=> !ctl[`TDC_B_ARMED]) // [RL3]
        else $error("channel stayed armed at terminal count");
    a_chg_guard: assert property (wCon && !wrData[`TDC_B_CHG] && !endCnt |=> $stable(ctl[`TDC_B_ARMED])) // [RL27]
        else $error("armed bit changed without change enable");
    a_count_dec: assert property (xferDone && !wCnt |=> count == $past(count) - CNT_W'(1)) // [RL26]
        else $error("count did not drop by one");
    a_irq_gate: assert property (tcIrq |-> $past(ctl[`TDC_B_TOC]) && $past(ctl[`TDC_B_IRQEN])) // [RL28]
        else $error("interrupt without terminate on count");
    a_ptr_hold: assert property (xferDone && !wSrcL && !wSrcH && ctl[`TDC_B_SINC] == ctl[`TDC_B_SDEC] // [RL22]
        |=> $stable(srcPtr))
        else $error("source pointer moved while constant");

endmodule
`default_nettype wire

// [dv/tdc_biu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module tdc_biu_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Pacing from the bench.
    input  wire logic [2:0] stall,
    input  wire logic       cpuBusy,
    // Bus interface unit link.
    input  wire logic       dmaReq_r,
    input  wire logic       nonCpuMasterStatus_r,
    output var  logic       biuGrant,
    output var  logic       biuCycleDone
);
    logic [1:0] phase;
    logic [2:0] waitCnt;

    // A refused grant leaves the status low, so the model falls back to idle instead of hanging.
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            biuGrant     <= 1'b0;
            biuCycleDone <= 1'b0;
            phase        <= 2'h0;
            waitCnt      <= 3'h0;
        end else begin
            biuGrant     <= 1'b0;
            biuCycleDone <= 1'b0;
            if (phase == 2'h0) begin
                if (dmaReq_r && !cpuBusy && !biuGrant) begin
                    biuGrant <= 1'b1;
                    phase    <= 2'h1;
                    waitCnt  <= stall;
                end
            end else if (!nonCpuMasterStatus_r) begin
                if (!biuGrant) begin
                    phase <= 2'h0;
                end
            end else if (waitCnt != 3'h0) begin
                waitCnt <= waitCnt - 3'h1;
            end else if (!biuCycleDone) begin
                biuCycleDone <= 1'b1;
                phase        <= (phase == 2'h2) ? 2'h0 : 2'h2;
                waitCnt      <= stall;
            end
        end
    end
endmodule

`default_nettype wire

// [dv/test_two_channel_dma_control.sv]
`timescale 1ns/1ps
`default_nettype none

module test_two_channel_dma_control;
    import tdc_pkg::*;

    logic        clk = 1'b0, rst = 1'b1, regWr, regRd, nmiEntry, nmiExit, cpuBusy;
    logic        biuGrant, biuCycleDone, dmaReq_r, busMemSpace_r, busWrite_r;
    logic        nonCpuMasterStatus_r, chipSelAllow_r, prevStat, prevWrite;
    logic [4:0]  regAddr;
    logic [15:0] regWrData, regRdData_r, d;
    logic [15:0] con[2];
    logic [1:0]  chanReq, tcIrq;
    logic [2:0]  stall;
    logic [31:0] seed = 32'h201b;
    tdc_addr_t   busAddr_r;
    int          src[2], dst[2], cnt[2], expQ[$], curCh;
    int          miscompares = 0, comparisons = 0, cycles = 0;

    tdc_dma_ctrl dut_u (.clk, .rst, .regWr, .regRd, .regAddr, .regWrData, .regRdData_r, .chanReq,
        .nmiEntry, .nmiExit, .biuGrant, .biuCycleDone, .dmaReq_r, .busAddr_r, .busMemSpace_r,
        .busWrite_r, .nonCpuMasterStatus_r, .chipSelAllow_r, .tcIrq);
    tdc_biu_model biu_u (.clk, .rst, .stall, .cpuBusy, .dmaReq_r, .nonCpuMasterStatus_r,
        .biuGrant, .biuCycleDone);

    always #12.5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int stepOf(input int c, input int incB, input int decB);
        int amt;
        amt = con[c][0] ? 2 : 1;
        if (con[c][incB] == con[c][decB]) return 0;
        return con[c][incB] ? amt : -amt;
    endfunction

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge clk);
        regAddr   = a;
        regWrData = v;
        regWr     = 1'b1;
        @(negedge clk);
        regWr = 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(negedge clk);
        regAddr = a;
        regRd   = 1'b1;
        @(negedge clk);
        regRd = 1'b0;
        d     = regRdData_r;
    endtask

    task automatic setup(input int c, input logic [15:0] cfg, input int n);
        logic [4:0] b;
        b      = 5'(c * 8);
        src[c] = int'(rnd() & 32'hfffff);
        dst[c] = int'(rnd() & 32'hfffff);
        cnt[c] = n;
        con[c] = cfg | 16'h0002;
        wr(b, src[c][15:0]);
        wr(b + 5'h1, {12'h000, src[c][19:16]});
        wr(b + 5'h2, dst[c][15:0]);
        wr(b + 5'h3, {12'h000, dst[c][19:16]});
        wr(b + 5'h4, 16'(n));
        wr(b + 5'h5, cfg | 16'h0006);
    endtask

    task automatic pulse(input logic entry);
        @(negedge clk);
        nmiEntry = entry;
        nmiExit  = !entry;
        @(negedge clk);
        nmiEntry = 1'b0;
        nmiExit  = 1'b0;
    endtask

    // The quiet tail after each drain is where a stray grant on a stopped channel shows up.
    task automatic drain();
        int t;
        t = 0;
        while ((expQ.size() != 0 || nonCpuMasterStatus_r !== 1'b0) && t < 600) begin
            @(negedge clk);
            t++;
        end
        chk("drain wait", 0, 20'(t == 600));
        repeat (20) @(negedge clk);
        chanReq = 2'b00;
    endtask

    task automatic waitBusy();
        int t;
        for (t = 0; t < 100 && nonCpuMasterStatus_r !== 1'b1; t++) @(negedge clk);
    endtask

    task automatic pair(input logic [15:0] c0, input logic [15:0] c1, input int q[4]);
        setup(0, c0, 2);
        setup(1, c1, 2);
        stall = 3'(rnd() % 4);
        foreach (q[i]) expQ.push_back(q[i]);
        chanReq = 2'b11;
        drain();
    endtask

    task automatic busChk(input logic [19:0] a, input logic m, input logic w);
        chk("bus addr", a, busAddr_r);
        chk("bus space", 20'(m), 20'(busMemSpace_r));
        chk("bus write", 20'(w), 20'(busWrite_r));
        chk("chip select", 20'(m || a[19:16] == 4'h0), 20'(chipSelAllow_r));
    endtask

    task automatic finishXfer(input int c);
        logic [1:0] expIrq;
        src[c]    = (src[c] + stepOf(c, 10, 11)) & 32'hfffff;
        dst[c]    = (dst[c] + stepOf(c, 13, 14)) & 32'hfffff;
        cnt[c]    = (cnt[c] - 1) & 32'hffff;
        expIrq    = 2'b00;
        expIrq[c] = cnt[c] == 0 && con[c][9] && con[c][8];
        chk("count irq", 20'(expIrq), 20'(tcIrq));
    endtask

    always @(negedge clk) begin
        if (!rst) begin
            if (nonCpuMasterStatus_r && !prevStat) begin
                curCh = 0;
                if (expQ.size() == 0) chk("unexpected transfer", 0, 1);
                else curCh = expQ.pop_front();
                busChk(20'(src[curCh]), con[curCh][12], 1'b0);
            end
            if (nonCpuMasterStatus_r && busWrite_r && !prevWrite) begin
                busChk(20'(dst[curCh]), con[curCh][15], 1'b1);
            end
            if (!nonCpuMasterStatus_r && prevStat) finishXfer(curCh);
            else if (tcIrq !== 2'b00) chk("stray irq", 0, 20'(tcIrq));
        end
        prevStat  = nonCpuMasterStatus_r;
        prevWrite = busWrite_r;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        {regWr, regRd, nmiEntry, nmiExit, cpuBusy, prevStat, prevWrite} = '0;
        regAddr   = '0;
        regWrData = '0;
        chanReq   = '0;
        stall     = 3'h2;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int a = 0; a < 17; a++) begin
            rd(5'(a));
            chk("reset read", 0, 20'(d));
        end
        wr(5'h01, 16'hffff);
        wr(5'h07, 16'hffff);
        rd(5'h01);
        chk("pointer high", 20'h0000f, 20'(d));
        rd(5'h07);
        chk("unmapped read", 0, 20'(d));
        wr(5'h05, 16'h0002);
        rd(5'h05);
        chk("arm without change", 0, 20'(d[1]));
        wr(5'h05, 16'h0004);
        // Unsynchronized word channel with no count stop still ends at zero.
        setup(0, 16'h4401 | (16'(rnd()) & 16'h9000), 3);
        expQ    = '{0, 0, 0};
        cpuBusy = 1'b1;
        chanReq = 2'b01;
        repeat (10) @(negedge clk);
        chk("request pending", 1, 20'(dmaReq_r));
        cpuBusy = 1'b0;
        drain();
        setup(1, 16'h2f20 | (16'(rnd()) & 16'h9000), 2);
        expQ    = '{1, 1};
        chanReq = 2'b10;
        drain();
        rd(5'h0d);
        chk("armed after count", 0, 20'(d[1]));
        pair(16'h2620, 16'h2630, '{1, 1, 0, 0});
        pair(16'h2620, 16'h2650, '{1, 0, 1, 0});
        pair(16'h2620, 16'h2620, '{1, 0, 1, 0});
        pair(16'h2630, 16'h2630, '{1, 0, 1, 0});
        setup(0, 16'h2630, 2);
        setup(1, 16'h2620, 3);
        expQ    = '{1, 0, 0, 1, 1};
        chanReq = 2'b10;
        waitBusy();
        chanReq = 2'b11;
        drain();
        setup(0, 16'h2620, 5);
        stall   = 3'h4;
        expQ    = '{0};
        chanReq = 2'b01;
        waitBusy();
        wr(5'h05, 16'h2624);
        drain();
        rd(5'h04);
        chk("count left", 20'(cnt[0]), 20'(d));
        for (int k = 0; k < 3; k++) begin
            setup(0, 16'h2400, 2);
            src[0] &= 32'hffff;
            dst[0] &= 32'hffff;
            wr(5'h01, 16'h0000);
            wr(5'h03, 16'h0000);
            if (k == 2) wr(5'h10, 16'h0001);
            else pulse(1'b1);
            chanReq = 2'b01;
            repeat (30) @(negedge clk);
            rd(5'h10);
            chk("hold state", (k == 2) ? 20'h5 : 20'h6, 20'({d[3], d[1:0]}));
            expQ = '{0, 0};
            if (k == 0) pulse(1'b0);
            else wr(5'h10, 16'(k == 1 ? 2 : 0));
            drain();
        end
        close_out();
    end
endmodule

`default_nettype wire
